// >>> pnp_ahb_front.sv
// ahb-lite address and data phase tracking for the partner next page register bank
`timescale 1ns/1ns
`default_nettype none
module pnp_ahb_front (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [pnp_pkg::ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   output pnp_pkg::pnp_req_t req
);
   typedef struct packed {
      logic wr_pend;
      logic [pnp_pkg::ADDR_W-1:0] wr_addr;
   } pnp_front_st_t;

   pnp_front_st_t s_q;
   pnp_front_st_t s_d;
   logic take;

   // only nonseq is taken; idle and busy leave the bank untouched
   assign take = hsel && hready && (htrans == pnp_pkg::HTRANS_NONSEQ);

   always_comb begin
      s_d = s_q;
      s_d.wr_pend = take && hwrite;
      if (take && hwrite) begin
         s_d.wr_addr = haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign req.rd_hit = take && !hwrite;
   assign req.rd_addr = haddr;
   assign req.wr_en = s_q.wr_pend;
   assign req.wr_addr = s_q.wr_addr;
endmodule // pnp_ahb_front
`default_nettype wire

// >>> pnp_lp_next_page.sv
// partner next page status register bank with ahb-lite slave
// Function
// - bit 15: partner wants another next page
// - bit 14: partner acknowledged ability word
// - acknowledge bit filled by negotiation, not software
// - bit 13: message page versus unformatted page
// - bits 10:0 hold received code field
// - bit 12: partner able to comply
// - bit 11: toggle of previous word
// - page received flag, cleared by reading
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pnp_lp_next_page (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic page_valid,
   input wire pnp_pkg::pnp_page_t page_in,
   output pnp_pkg::pnp_page_t partner_page,
   output logic page_rx
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      pnp_pkg::pnp_page_t word;
      logic page_rx;
      logic [31:0] rdata;
      logic ready;
   } pnp_st_t;

   pnp_st_t s_q;
   pnp_st_t s_d;
   pnp_pkg::pnp_req_t req;

   // ************************************************************
   // bus front end
   // ************************************************************
   pnp_ahb_front u_front (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr[pnp_pkg::ADDR_W-1:0]),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .req(req)
   );

   // ************************************************************
   // register bank
   // ************************************************************
   always_comb begin
      s_d = s_q;
      s_d.ready = 1'b1;
      s_d.rdata = 32'h00000000;
      // only the code field takes software writes; hsize is ignored since only words are used
      if (req.wr_en && (req.wr_addr == pnp_pkg::OFS_PAGE_WORD)) begin
         s_d.word.code = hwdata[pnp_pkg::CODE_W-1:0];
      end
      // read data is sampled at the address phase so the data phase needs no wait state
      if (req.rd_hit) begin
         case (req.rd_addr)
            pnp_pkg::OFS_PAGE_WORD: begin
               s_d.rdata[pnp_pkg::WORD_W-1:0] = s_q.word;
            end
            pnp_pkg::OFS_PAGE_STAT: begin
               s_d.rdata[pnp_pkg::STAT_PAGE_RX_BIT] = s_q.page_rx;
               s_d.page_rx = 1'b0;
            end
            default: begin
               s_d.rdata = 32'h00000000;
            end
         endcase
      end
      // a page arriving with a clear or a code write wins, so no event is lost
      if (page_valid) begin
         s_d.word = page_in;
         s_d.page_rx = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // reset values are constants only; fields read zero until the first page or code write
         s_q <= '{
            word: pnp_pkg::PAGE_RST,
            page_rx: 1'b0,
            rdata: 32'h00000000,
            ready: 1'b1
         };
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.ready;
   assign hresp = pnp_pkg::HRESP_OKAY;
   assign hrdata = s_q.rdata;
   assign partner_page = s_q.word;
   assign page_rx = s_q.page_rx;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // decoded views of the bus request and the outputs, used by the checks only
   logic rd_stat;
   logic rd_word;
   logic rd_other;
   logic wr_word;
   logic wr_stat;
   logic wr_take;
   logic [pnp_pkg::WORD_W-pnp_pkg::CODE_W-1:0] page_upper;
   logic [pnp_pkg::CODE_W-1:0] wdata_code;
   logic [31:0] page_wide;
   logic [31:0] stat_only;
   assign rd_stat = req.rd_hit && (req.rd_addr == pnp_pkg::OFS_PAGE_STAT);
   assign rd_word = req.rd_hit && (req.rd_addr == pnp_pkg::OFS_PAGE_WORD);
   assign rd_other = req.rd_hit && !rd_stat && !rd_word;
   assign wr_word = req.wr_en && (req.wr_addr == pnp_pkg::OFS_PAGE_WORD);
   assign wr_stat = req.wr_en && (req.wr_addr == pnp_pkg::OFS_PAGE_STAT);
   assign wr_take = hsel && hready && (htrans == pnp_pkg::HTRANS_NONSEQ) && hwrite;
   assign page_upper = partner_page[pnp_pkg::WORD_W-1:pnp_pkg::CODE_W];
   assign wdata_code = hwdata[pnp_pkg::CODE_W-1:0];
   assign page_wide = {{(32-pnp_pkg::WORD_W){1'b0}}, partner_page};
   assign stat_only = 32'(hrdata[pnp_pkg::STAT_PAGE_RX_BIT]) << pnp_pkg::STAT_PAGE_RX_BIT;

   // ************************************************************
   // page capture
   // ************************************************************
   a_more_pages_bit: assert property (page_valid |=> partner_page.more_pages_wanted == $past(page_in[15]))
      else $error("more pages bit not taken from page");
   a_ack_bit: assert property (page_valid |=> partner_page.ack == $past(page_in[14]))
      else $error("acknowledge bit not taken from page");
   a_ack_hw_only: assert property (!page_valid |=> $stable(partner_page.ack))
      else $error("acknowledge bit changed without a page");
   a_msg_page_bit: assert property (page_valid |=> partner_page.message_page_flag == $past(page_in[13]))
      else $error("message page bit not taken from page");
   a_code_field: assert property (page_valid |=> partner_page.code == $past(page_in[10:0]))
      else $error("code field not taken from page");
   a_comply_bit: assert property (page_valid |=> partner_page.comply_ack == $past(page_in[12]))
      else $error("comply bit not taken from page");
   a_toggle_bit: assert property (page_valid |=> partner_page.toggle == $past(page_in[11]))
      else $error("toggle bit not taken from page");
   a_reload_hold: assert property (!page_valid && !req.wr_en |=> $stable(partner_page))
      else $error("page fields changed without a page or write");
   // software reaches only the code field; the upper bits belong to negotiation
   a_write_upper_kept: assert property (wr_word && !page_valid |=> $stable(page_upper))
      else $error("code write disturbed the upper page bits");
   a_code_write: assert property (wr_word && !page_valid |=> partner_page.code == $past(wdata_code))
      else $error("code write did not land");
   // a page on the write edge is kept whole, so no received word is torn
   a_page_wins_write: assert property (wr_word && page_valid |=> partner_page == $past(page_in))
      else $error("code write overrode a received page");

   // ************************************************************
   // page received flag
   // ************************************************************
   a_flag_set: assert property (page_valid |=> page_rx)
      else $error("page received flag not set");
   a_flag_clear: assert property (rd_stat && !page_valid |=> !page_rx && stat_only == 32'($past(page_rx)) << 1)
      else $error("status read did not clear flag or return it");
   // set beats clear: the read returns the old flag and the new page stays visible
   a_set_wins: assert property (rd_stat && page_valid |=> page_rx)
      else $error("page received flag lost to a status read");
   a_flag_hold: assert property (!page_valid && !rd_stat |=> $stable(page_rx))
      else $error("page received flag changed without a page or read");
   a_flag_no_stray: assert property (!page_valid |=> !$rose(page_rx))
      else $error("page received flag rose without a page");
   a_stat_write_ignored: assert property (wr_stat && !page_valid && !rd_stat |=> page_rx == $past(page_rx))
      else $error("status write disturbed the page received flag");

   // ************************************************************
   // bus read path
   // ************************************************************
   // hrdata is zero outside a data phase, so a stale word never shows on an idle cycle
   a_idle_zero: assert property (!req.rd_hit |=> hrdata == 32'h00000000)
      else $error("read data not zero outside a data phase");
   a_word_read: assert property (rd_word |=> hrdata == $past(page_wide))
      else $error("page word read returned wrong data");
   a_stat_read_bits: assert property (rd_stat |=> hrdata == stat_only)
      else $error("status read set bits other than the flag");
   a_unmapped_zero: assert property (rd_other |=> hrdata == 32'h00000000)
      else $error("unmapped read returned nonzero data");
   a_ready_high: assert property (hreadyout && hresp == pnp_pkg::HRESP_OKAY)
      else $error("bus answer not ready okay");

   // ************************************************************
   // write capture
   // ************************************************************
   // the write lands one edge late, when hwdata stands in the data phase
   a_write_taken: assert property (wr_take |=> req.wr_en)
      else $error("write address phase not carried to the data phase");
   a_no_stray_write: assert property (!wr_take |=> !req.wr_en)
      else $error("write applied without a write address phase");

   // ************************************************************
   // cover points
   // ************************************************************
   c_page_rx: cover property (page_valid ##1 rd_stat);
   c_clear_race: cover property (rd_stat && page_valid);
   c_code_write: cover property (req.wr_en && req.wr_addr == pnp_pkg::OFS_PAGE_WORD);
   c_unformatted_page: cover property (page_valid && !page_in.message_page_flag);
   c_page_over_write: cover property (wr_word && page_valid);
endmodule // pnp_lp_next_page
`default_nettype wire

// >>> pnp_partner.sv
// remote partner model offering next pages to the negotiation input
`timescale 1ns/1ns
`default_nettype none
module pnp_partner (
   input wire logic hclk,
   input wire logic go,
   input wire pnp_pkg::pnp_page_t word,
   output pnp_pkg::pnp_page_t page_in,
   output logic page_valid
);
   initial begin
      page_valid = 1'h0;
      page_in = 16'h0000;
   end
   // between pulses the page bus churns so a stale word cannot pass
   always @(posedge hclk) begin
      page_valid <= go;
      page_in <= go ? word : ~page_in;
   end
endmodule // pnp_partner
`default_nettype wire

// >>> pnp_pkg.sv
// package: register map, field layout and carriers for the partner next page register bank
package pnp_pkg;
   // ************************************************************
   // register map (byte addresses on the ahb-lite bus)
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_PAGE_WORD = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PAGE_STAT = 4'h4;

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int CODE_W = 11;
   localparam int WORD_W = 16;
   localparam int STAT_PAGE_RX_BIT = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // received next page, bit 15 down to bit 0
   typedef struct packed {
      logic more_pages_wanted;
      logic ack;
      logic message_page_flag;
      logic comply_ack;
      logic toggle;
      logic [CODE_W-1:0] code;
   } pnp_page_t;

   localparam pnp_page_t PAGE_RST = 16'h0000;

   // register access request from the bus front end
   typedef struct packed {
      logic rd_hit;
      logic [ADDR_W-1:0] rd_addr;
      logic wr_en;
      logic [ADDR_W-1:0] wr_addr;
   } pnp_req_t;
endpackage

// >>> tb_pnp_lp_next_page.sv
// self-checking bench for the partner next page register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_pnp_lp_next_page;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0, rd_dp = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, st = 32'h76554A7E, ex, exq;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   wire logic hreadyout, hresp, page_valid, page_rx;
   wire logic [31:0] hrdata;
   wire pnp_pkg::pnp_page_t page_in, partner_page;
   pnp_pkg::pnp_page_t word = 16'h0000, pg = 16'h0000;
   int compares = 0, miscompares = 0;
   logic [31:0] rq[$];
   always #5 hclk = ~hclk;
   pnp_lp_next_page DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .page_valid(page_valid), .page_in(page_in),
      .partner_page(partner_page), .page_rx(page_rx));
   pnp_partner PARTNER (.hclk(hclk), .go(go), .word(word), .page_in(page_in), .page_valid(page_valid));
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   task automatic end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // no fixed latency assumed: wait for hready under a bound
   task automatic wrdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'h1 && n < 50);
      if (hreadyout !== 1'h1) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [31:0] e);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= pnp_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      wrdy();
      if (!wr) rq.push_back(e);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wrdy();
   endtask
   task automatic send(input pnp_pkg::pnp_page_t w);
      @(posedge hclk);
      go <= 1'h1;
      word <= w;
      @(posedge hclk);
      go <= 1'h0;
      @(posedge hclk);
      #1;
      pg = w;
      `CHK("partner_page", w, partner_page)
      `CHK("page_rx", 1'h1, page_rx)
   endtask
   // read data is checked at the end of its data phase, oldest note first
   always @(posedge hclk) begin
      if (rd_dp && hreadyout === 1'h1) begin
         exq = rq.pop_front();
         `CHK("hrdata", exq, hrdata)
         `CHK("hresp", pnp_pkg::HRESP_OKAY, hresp)
      end
      rd_dp <= hsel && hreadyout && htrans == pnp_pkg::HTRANS_NONSEQ && !hwrite;
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      xfer(1'h0, 32'h4, 32'h0, 32'h0);
      xfer(1'h0, 32'h0, 32'h0, 32'h0);
      repeat (8) begin
         ex = rnd();
         send(ex[15:0]);
         xfer(1'h0, 32'h0, 32'h0, {16'h0000, pg});
         xfer(1'h0, 32'h4, 32'h0, 32'h2);
         xfer(1'h0, 32'h4, 32'h0, 32'h0);
         ex = rnd();
         xfer(1'h1, 32'h0, ex, 32'h0);
         pg.code = ex[10:0];
         xfer(1'h0, 32'h0, 32'h0, {16'h0000, pg});
      end
      // a page on the edge of a status read or a code write must win
      ex = rnd();
      fork
         send(ex[15:0]);
         begin
            @(posedge hclk);
            xfer(1'h0, 32'h4, 32'h0, 32'h0);
         end
      join
      xfer(1'h0, 32'h4, 32'h0, 32'h2);
      ex = rnd();
      fork
         send(ex[15:0]);
         xfer(1'h1, 32'h0, ~ex, 32'h0);
      join
      xfer(1'h0, 32'h0, 32'h0, {16'h0000, pg});
      xfer(1'h1, 32'h4, 32'hFFFFFFFF, 32'h0);
      xfer(1'h0, 32'h4, 32'h0, 32'h2);
      xfer(1'h0, 32'h8, 32'h0, 32'h0);
      @(posedge hclk);
      `CHK("pending", 0, rq.size())
      end_of_test();
   end
endmodule // tb_pnp_lp_next_page
`default_nettype wire
